// ==== hw/smr_pkg.sv ====
// Constants, field layouts and types of the serial measurement reporter.
// Assumes a 20 MHz bus clock from which every bit rate is derived.
package smr_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_HZ     = 20_000_000;
	localparam int ONE_SEC_MS = 1000;
	localparam int SEC_CYCLES = CLK_HZ / 1000 * ONE_SEC_MS;
	localparam int RTU_GAP_BITS = 35;           // 3.5 character times of 10 bits

	// ----------------------------------------
	// Bit rates
	// ----------------------------------------
	localparam int RATE_0 = 9600;
	localparam int RATE_1 = 19200;
	localparam int RATE_2 = 38400;
	localparam int RATE_3 = 56000;
	localparam int RATE_4 = 57600;
	localparam int RATE_5 = 115200;
	localparam logic [2:0] BAUD_MAX = 3'h5;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_BAUD   = 8'h04;
	localparam logic [7:0] OFS_PAR    = 8'h08;
	localparam logic [7:0] OFS_IVAL   = 8'h0C;
	localparam logic [7:0] OFS_SLAVE  = 8'h10;
	localparam logic [7:0] OFS_TXCHR  = 8'h14;
	localparam logic [7:0] OFS_STAT   = 8'h18;
	localparam logic [7:0] OFS_RXDAT  = 8'h1C;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTRL_EN    = 0;
	localparam int CTRL_MB    = 1;
	localparam int CTRL_RTU   = 2;
	localparam int CTRL_LITTLE = 3;
	localparam int CTRL_FRST  = 4;
	localparam int IVAL_HH    = 16;
	localparam int IVAL_MM    = 8;
	localparam int IVAL_SS    = 0;
	localparam int TX_SEMI    = 8;
	localparam int TX_EOR     = 9;

	// ----------------------------------------
	// Character format and special characters
	// ----------------------------------------
	localparam logic [3:0] DATA_BITS = 4'h8;
	localparam logic [1:0] STOP_BITS = 2'h1;
	localparam logic [7:0] CHR_SEMI  = 8'h3B;
	localparam logic [7:0] CHR_CR    = 8'h0D;
	localparam logic [7:0] CHR_LF    = 8'h0A;
	localparam logic [7:0] CHR_COLON = 8'h3A;
	localparam logic [4:0] HH_MAX    = 5'h17;
	localparam logic [5:0] MS_MAX    = 6'h3B;
	localparam logic [7:0] SLAVE_MAX = 8'hF7;

	typedef enum logic [1:0] {PAR_NONE = 2'h0, PAR_ODD = 2'h1, PAR_EVEN = 2'h2} smr_par_e;
	typedef enum logic [2:0] {
		S_IDLE = 3'h0, S_START = 3'h1, S_DATA = 3'h2, S_PAR = 3'h3, S_STOP = 3'h4
	} smr_bit_e;

	typedef struct packed {
		logic       en;
		logic       mb;
		logic       rtu;
		logic       little;
		logic [2:0] baud;
		smr_par_e   par;
		logic [4:0] hh;
		logic [5:0] mm;
		logic [5:0] ss;
		logic [7:0] slave;
	} smr_cfg_s;

	localparam smr_cfg_s CFG_RST = '{
		en: 1'b0, mb: 1'b0, rtu: 1'b0, little: 1'b0, baud: 3'h0, par: PAR_NONE,
		hh: 5'h00, mm: 6'h00, ss: 6'h01, slave: 8'h01
	};

endpackage : smr_pkg

// ==== hw/smr_top.sv ====
// Serial measurement reporter: AHB-Lite register slave, record pacing,
// 8N1/8E1/8O1 transmitter and a receiver with Modbus slave address filter.
// Assumes rxd is already synchronous to hclk and a single bus master.
`timescale 1ns/1ps
module smr_top
	import smr_pkg::*;
#(
	parameter int SEC_CNT = SEC_CYCLES
)(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Serial line
	output logic             txd,
	output logic             tx_drive,
	input  wire logic        rxd
);
	import smr_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [11:0] baud_div(input logic [2:0] sel);
		unique case (sel)
			3'h1:    baud_div = 12'((CLK_HZ + RATE_1 / 2) / RATE_1);
			3'h2:    baud_div = 12'((CLK_HZ + RATE_2 / 2) / RATE_2);
			3'h3:    baud_div = 12'((CLK_HZ + RATE_3 / 2) / RATE_3);
			3'h4:    baud_div = 12'((CLK_HZ + RATE_4 / 2) / RATE_4);
			3'h5:    baud_div = 12'((CLK_HZ + RATE_5 / 2) / RATE_5);
			default: baud_div = 12'((CLK_HZ + RATE_0 / 2) / RATE_0);
		endcase
	endfunction : baud_div

	// Parity bit to send or expect; odd makes the one count odd
	function automatic logic par_bit(input logic [7:0] d, input smr_par_e p);
		par_bit = (^d) ^ (p == PAR_ODD);
	endfunction : par_bit

	smr_cfg_s    cfg_r;
	logic [11:0] div;
	logic        ap_wr_r;
	logic [7:0]  ap_adr_r;
	logic        ap;
	logic        wr;
	logic        en_d_r;
	logic        due_r;
	logic [24:0] sec_r;
	logic [16:0] el_r;
	logic [16:0] ival;
	logic [15:0] pend_r;
	logic [1:0]  pcnt_r;
	logic        tx_take;
	smr_bit_e    tx_st_r;
	logic [11:0] tx_c_r;
	logic [3:0]  tx_n_r;
	logic [7:0]  tx_sh_r;
	logic [7:0]  tx_chr_r;
	logic        tx_tick;
	smr_bit_e    rx_st_r;
	logic [11:0] rx_c_r;
	logic [3:0]  rx_n_r;
	logic [7:0]  rx_sh_r;
	logic        rx_tick;
	logic        rx_done;
	logic        rx_perr;
	logic [15:0] rx_dat_r;
	logic        rx_val_r;
	logic        perr_r;
	logic [6:0]  gap_r;
	logic        own_r;
	logic [1:0]  hex_n_r;
	logic [3:0]  hex_hi_r;
	logic [3:0]  nib;
	logic [7:0]  rx_addr;
	logic        rx_keep;

	assign div       = baud_div(cfg_r.baud);
	assign hreadyout = 1'b1;                 // Zero wait states, always OKAY
	assign hresp     = 1'b0;

	// ----------------------------------------
	// AHB-Lite address and data phases
	// ----------------------------------------
	assign ap = hsel & htrans[1] & hready;
	assign wr = ap_wr_r;

	// Latch the address phase; writes complete in the following data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ap_wr_r  <= 1'b0;
			ap_adr_r <= 8'h00;
		end
		else
		begin
			ap_wr_r  <= ap & hwrite;
			ap_adr_r <= ap ? haddr[7:0] : ap_adr_r;
		end
	end

	// Read data is loaded at the address phase so it stands through the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (ap & !hwrite)
		begin
			unique case (haddr[7:0])
				OFS_CTRL:  hrdata <= {28'h0, cfg_r.little, cfg_r.rtu, cfg_r.mb, cfg_r.en};
				OFS_BAUD:  hrdata <= {29'h0, cfg_r.baud};
				OFS_PAR:   hrdata <= {30'h0, cfg_r.par};
				OFS_IVAL:  hrdata <= {11'h0, cfg_r.hh, 2'h0, cfg_r.mm, 2'h0, cfg_r.ss};
				OFS_SLAVE: hrdata <= {24'h0, cfg_r.slave};
				OFS_STAT:  hrdata <= {26'h0, own_r, perr_r, rx_val_r, due_r,
					tx_st_r != S_IDLE, pcnt_r != 2'h0};
				OFS_RXDAT: hrdata <= {16'h0, cfg_r.little ? {rx_dat_r[7:0], rx_dat_r[15:8]}
					: rx_dat_r};
				default:   hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	// Out-of-range values are ignored so the setting always stays legal
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cfg_r <= CFG_RST;
		else if (wr)
		begin
			unique case (ap_adr_r)
				OFS_CTRL:
					if (hwdata[CTRL_FRST])
						cfg_r <= CFG_RST;
					else
					begin
						cfg_r.en     <= hwdata[CTRL_EN];
						cfg_r.mb     <= hwdata[CTRL_MB];
						cfg_r.rtu    <= hwdata[CTRL_RTU];
						cfg_r.little <= hwdata[CTRL_LITTLE];
					end
				OFS_BAUD:
					if (hwdata[2:0] <= BAUD_MAX)
						cfg_r.baud <= hwdata[2:0];
				OFS_PAR:
					if (hwdata[1:0] != 2'h3)
						cfg_r.par <= smr_par_e'(hwdata[1:0]);
				OFS_IVAL:
					if (hwdata[IVAL_HH+:5] <= HH_MAX && hwdata[IVAL_MM+:6] <= MS_MAX
						&& hwdata[IVAL_SS+:6] <= MS_MAX)
					begin
						cfg_r.hh <= hwdata[IVAL_HH+:5];
						cfg_r.mm <= hwdata[IVAL_MM+:6];
						cfg_r.ss <= hwdata[IVAL_SS+:6];
					end
				OFS_SLAVE:
					if (hwdata[7:0] != 8'h00 && hwdata[7:0] <= SLAVE_MAX)
						cfg_r.slave <= hwdata[7:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Record pacing
	// ----------------------------------------
	// A zero interval would stall; it is treated as one second
	assign ival = (17'(cfg_r.hh) * 17'h0E10 + 17'(cfg_r.mm) * 17'h003C + 17'(cfg_r.ss)) == 17'h0
		? 17'h00001 : 17'(cfg_r.hh) * 17'h0E10 + 17'(cfg_r.mm) * 17'h003C + 17'(cfg_r.ss);

	// Seconds counter runs only while records are enabled
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			en_d_r <= 1'b0;
			sec_r  <= 25'h0;
			el_r   <= 17'h0;
		end
		else
		begin
			en_d_r <= cfg_r.en;
			if (!cfg_r.en || cfg_r.mb || (cfg_r.en && !en_d_r))
			begin
				sec_r <= 25'h0;
				el_r  <= 17'h0;
			end
			else if (sec_r == 25'(SEC_CNT - 1))
			begin
				sec_r <= 25'h0;
				el_r  <= (el_r + 17'h1 >= ival) ? 17'h0 : el_r + 17'h1;
			end
			else
				sec_r <= sec_r + 25'h1;
		end
	end

	// Record due: set on enable edge and each interval, set beats the EOR clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			due_r <= 1'b0;
		else if (!cfg_r.en || cfg_r.mb)
			due_r <= 1'b0;
		else if ((cfg_r.en && !en_d_r) ||
			(sec_r == 25'(SEC_CNT - 1) && el_r + 17'h1 >= ival))
			due_r <= 1'b1;
		else if (wr && ap_adr_r == OFS_TXCHR && hwdata[TX_EOR])
			due_r <= 1'b0;
	end

	// ----------------------------------------
	// Character queue
	// ----------------------------------------
	// Software supplies each field's digits; the block adds separators
	// and the line end. A write while bytes are pending is dropped.
	assign tx_take = (tx_st_r == S_IDLE) && (pcnt_r != 2'h0);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pend_r <= 16'h0000;
			pcnt_r <= 2'h0;
		end
		else if (wr && ap_adr_r == OFS_TXCHR && pcnt_r == 2'h0)
		begin
			if (hwdata[TX_EOR])
			begin
				pend_r <= {CHR_CR, CHR_LF};
				pcnt_r <= 2'h2;
			end
			else if (hwdata[TX_SEMI])
			begin
				pend_r <= {hwdata[7:0], CHR_SEMI};
				pcnt_r <= 2'h2;
			end
			else
			begin
				pend_r <= {hwdata[7:0], 8'h00};
				pcnt_r <= 2'h1;
			end
		end
		else if (tx_take)
		begin
			pend_r <= {pend_r[7:0], 8'h00};
			pcnt_r <= pcnt_r - 2'h1;
		end
	end

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	assign tx_tick = (tx_c_r == div - 12'h1);

	// One bit time per state step; the divider restarts with every frame
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tx_st_r <= S_IDLE;
			tx_c_r  <= 12'h0;
			tx_n_r  <= 4'h0;
			tx_sh_r <= 8'h00;
			txd     <= 1'b1;
		end
		else
		begin
			tx_c_r <= (tx_st_r == S_IDLE || tx_tick) ? 12'h0 : tx_c_r + 12'h1;
			unique case (tx_st_r)
				S_IDLE:
					if (tx_take)
					begin
						tx_sh_r <= pend_r[15:8];
						tx_st_r <= S_START;
						txd     <= 1'b0;
					end
				S_START:
					if (tx_tick)
					begin
						tx_st_r <= S_DATA;
						tx_n_r  <= 4'h0;
						txd     <= tx_sh_r[0];
					end
				S_DATA:
					if (tx_tick)
					begin
						tx_sh_r <= {1'b0, tx_sh_r[7:1]};
						tx_n_r  <= tx_n_r + 4'h1;
						if (tx_n_r == DATA_BITS - 4'h1)
						begin
							tx_st_r <= (cfg_r.par == PAR_NONE) ? S_STOP : S_PAR;
							txd     <= (cfg_r.par == PAR_NONE) ? 1'b1
								: par_bit(tx_chr_r, cfg_r.par);
						end
						else
							txd <= tx_sh_r[1];
					end
				S_PAR:
					if (tx_tick)
					begin
						tx_st_r <= S_STOP;
						txd     <= 1'b1;
					end
				S_STOP:
					if (tx_tick)
						tx_st_r <= S_IDLE;
				default:
					tx_st_r <= S_IDLE;
			endcase
		end
	end

	// Copy of the character in flight; the shifter is empty by the parity bit
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			tx_chr_r <= 8'h00;
		else if (tx_take)
			tx_chr_r <= pend_r[15:8];
	end

	// RS485 driver stays on for the whole character including stop bit
	assign tx_drive = (tx_st_r != S_IDLE);

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	assign rx_tick = (rx_c_r == ((rx_st_r == S_START) ? {1'b0, div[11:1]} : div - 12'h1));
	assign rx_done = (rx_st_r == S_STOP) && rx_tick && rxd;

	// Start is confirmed at mid-bit; all later samples fall mid-bit too
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rx_st_r <= S_IDLE;
			rx_c_r  <= 12'h0;
			rx_n_r  <= 4'h0;
			rx_sh_r <= 8'h00;
			rx_perr <= 1'b0;
		end
		else
		begin
			// Idle line keeps counting bit times so the RTU gap can be measured
			rx_c_r <= (rx_tick || (rx_st_r == S_IDLE && !rxd)) ? 12'h0 : rx_c_r + 12'h1;
			unique case (rx_st_r)
				S_IDLE:
					if (!rxd)
						rx_st_r <= S_START;
				S_START:
					if (rx_tick)
					begin
						rx_st_r <= rxd ? S_IDLE : S_DATA;
						rx_n_r  <= 4'h0;
						rx_perr <= 1'b0; // No stale error into a no-parity frame
					end
				S_DATA:
					if (rx_tick)
					begin
						rx_sh_r <= {rxd, rx_sh_r[7:1]};
						rx_n_r  <= rx_n_r + 4'h1;
						if (rx_n_r == DATA_BITS - 4'h1)
							rx_st_r <= (cfg_r.par == PAR_NONE) ? S_STOP : S_PAR;
					end
				S_PAR:
					if (rx_tick)
					begin
						rx_perr <= (rxd != par_bit(rx_sh_r, cfg_r.par));
						rx_st_r <= S_STOP;
					end
				S_STOP:
					if (rx_tick)
					begin
						rx_st_r <= S_IDLE;
						if (!rx_done)
							rx_perr <= 1'b0;
					end
				default:
					rx_st_r <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Modbus framing and address filter
	// ----------------------------------------
	assign nib     = (rx_sh_r >= 8'h41) ? 4'(rx_sh_r - 8'h37) : rx_sh_r[3:0];
	assign rx_addr = cfg_r.rtu ? rx_sh_r : {hex_hi_r, nib};

	// RTU frames open after a silent gap, ASCII frames with a colon
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			gap_r    <= 7'h0;
			own_r    <= 1'b0;
			hex_n_r  <= 2'h0;
			hex_hi_r <= 4'h0;
		end
		else
		begin
			// Cleared only when a byte ends, so the first byte still sees its gap
			if (rx_done)
				gap_r <= 7'h0;
			else if (rx_st_r == S_IDLE && rx_tick)
				gap_r <= (gap_r == 7'(RTU_GAP_BITS)) ? gap_r : gap_r + 7'h1;
			if (rx_done && cfg_r.mb)
			begin
				if (cfg_r.rtu && gap_r == 7'(RTU_GAP_BITS))
					own_r <= (rx_addr == cfg_r.slave);
				else if (!cfg_r.rtu && rx_sh_r == CHR_COLON)
				begin
					hex_n_r <= 2'h1;
					own_r   <= 1'b0;
				end
				else if (!cfg_r.rtu && hex_n_r == 2'h1)
				begin
					hex_hi_r <= nib;
					hex_n_r  <= 2'h2;
				end
				else if (!cfg_r.rtu && hex_n_r == 2'h2)
				begin
					own_r   <= (rx_addr == cfg_r.slave);
					hex_n_r <= 2'h0;
				end
			end
		end
	end

	// Bytes of foreign frames never reach software, save an ASCII colon that follows an own frame
	assign rx_keep = rx_done && (!cfg_r.mb || (cfg_r.rtu ? (gap_r == 7'(RTU_GAP_BITS)
		? rx_sh_r == cfg_r.slave : own_r) : (own_r || hex_n_r == 2'h2
		&& rx_addr == cfg_r.slave)));

	// Received data, sticky parity error; a new byte wins over the read clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rx_dat_r <= 16'h0000;
			rx_val_r <= 1'b0;
			perr_r   <= 1'b0;
		end
		else
		begin
			if (rx_keep)
			begin
				rx_dat_r <= {rx_dat_r[7:0], rx_sh_r};
				rx_val_r <= 1'b1;
			end
			else if (ap && !hwrite && haddr[7:0] == OFS_RXDAT)
				rx_val_r <= 1'b0;
			if (rx_done && rx_perr)
				perr_r <= 1'b1;
			else if (wr && ap_adr_r == OFS_STAT && hwdata[3])
				perr_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	stop_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
		tx_st_r == S_STOP |-> txd) else $error("stop bit not high");
	start_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(tx_drive) |-> !txd ##1 !txd) else $error("start bit not low");
	no_rec_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!cfg_r.en |=> !due_r) else $error("record due while disabled");
	en_rise_a: assert property (@(posedge hclk) disable iff (!hresetn)
		cfg_r.en && !en_d_r && !cfg_r.mb |=> due_r) else $error("no record after enable");
	baud_rng_a: assert property (@(posedge hclk) disable iff (!hresetn)
		cfg_r.baud <= BAUD_MAX && div >= 12'h0AE) else $error("bad bit rate");
	par_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rx_done && rx_perr |=> perr_r) else $error("parity error lost");
	data_cnt_a: assert property (@(posedge hclk) disable iff (!hresetn)
		tx_st_r == S_DATA |-> tx_n_r < DATA_BITS) else $error("data count over");
	ival_rng_a: assert property (@(posedge hclk) disable iff (!hresetn)
		cfg_r.hh <= HH_MAX && cfg_r.mm <= MS_MAX && cfg_r.ss <= MS_MAX)
		else $error("interval out of range");
	fact_rst_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr && ap_adr_r == OFS_CTRL && hwdata[CTRL_FRST] |=> cfg_r == CFG_RST)
		else $error("factory reset missed");
	line_end_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr && ap_adr_r == OFS_TXCHR && hwdata[TX_EOR] && pcnt_r == 2'h0
		|=> pend_r == {CHR_CR, CHR_LF}) else $error("line end not queued");
	slave_rng_a: assert property (@(posedge hclk) disable iff (!hresetn)
		cfg_r.slave != 8'h00 && cfg_r.slave <= SLAVE_MAX) else $error("slave address bad");

endmodule : smr_top

// ==== tb/smr_partner.sv ====
// Far-end terminal model: decodes characters on txd, sends characters on rxd.
// Assumes the bench sets bit time and parity to match the device settings.
`timescale 1ns/1ps
module smr_partner
	import smr_pkg::*;
(
	// Clock and line
	input  wire logic        hclk,
	input  wire logic        txd,
	input  wire logic        tx_drive,
	output logic             rxd,
	// Settings shared with the device
	input  wire logic [15:0] bit_cyc,
	input  wire smr_par_e    par
);
	logic [7:0] got_q[$];   // Decoded characters, oldest first
	logic       bad;        // Framing, parity or driver fault seen

	// Idle line is high, so nothing looks like a start bit
	initial
	begin
		rxd = 1'b1;
		bad = 1'b0;
	end

	// ----------------------------------------
	// Receiver: samples each bit in its middle
	// ----------------------------------------
	always
	begin : rx_p
		logic [7:0] d;
		@(negedge txd);
		repeat (bit_cyc / 2) @(posedge hclk);
		bad = bad | (txd !== 1'b0) | (tx_drive !== 1'b1);
		for (int i = 0; i < 8; i++)
		begin
			repeat (bit_cyc) @(posedge hclk); // Same rate both ends
			d[i] = txd; // Eight bits, LSB first
		end
		if (par != PAR_NONE)
		begin
			repeat (bit_cyc) @(posedge hclk);
			bad = bad | (txd !== (^d ^ (par == PAR_ODD)));
		end
		repeat (bit_cyc) @(posedge hclk);
		bad = bad | (txd !== 1'b1); // One stop bit
		got_q.push_back(d);
	end

	// ----------------------------------------
	// Sender: the bus master side of the link
	// ----------------------------------------
	// Flip corrupts the parity bit on purpose; a spare stop bit is harmless
	task automatic send(input logic [7:0] d, input logic flip);
		logic [10:0] f;
		f = {2'h3, d, 1'b0};
		if (par != PAR_NONE)
			f[9] = ^d ^ (par == PAR_ODD) ^ flip;
		for (int i = 0; i < 11; i++)
		begin
			rxd <= f[i];
			repeat (bit_cyc) @(posedge hclk);
		end
	endtask : send
endmodule : smr_partner

// ==== tb/test_smr_top.sv ====
// Self-checking bench of the serial measurement reporter.
// Assumes one AHB-Lite master (this bench) and the terminal model on the line.
`timescale 1ns/1ps
module test_smr_top;
	import smr_pkg::*;
	logic        hclk = 1'b0;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hready;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        txd;
	logic        tx_drive;
	logic        rxd;
	logic [15:0] bit_cyc;
	smr_par_e    par_m;
	logic [31:0] r;
	int          num_errors = 0;
	int          checked = 0;
	int          cyc = 0;

	always #25 hclk = ~hclk;
	assign hready = hreadyout; // Single slave drives the bus ready

	// Short second keeps record pacing within reach of the run
	smr_top #(.SEC_CNT(200)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.txd(txd), .tx_drive(tx_drive), .rxd(rxd));
	smr_partner term (.hclk(hclk), .txd(txd), .tx_drive(tx_drive), .rxd(rxd),
		.bit_cyc(bit_cyc), .par(par_m));

	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask : cmp

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, r);
	endtask : wr

	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, r);
		cmp(r, e);
	endtask : chk

	// Polls status until queue and transmitter are both empty
	task automatic wait_idle;
		r = 32'h3;
		for (int i = 0; i < 20000 && r[1:0] != 2'h0; i++)
			bus(1'b0, OFS_STAT, 32'h0, r);
	endtask : wait_idle

	task automatic rx_is(input logic [7:0] e);
		cmp({24'h0, (term.got_q.size() > 0) ? term.got_q.pop_front() : 8'hXX}, {24'h0, e});
	endtask : rx_is

	// An RTU frame starts only after a long quiet line
	task automatic rtu_gap;
		repeat (36 * 174) @(posedge hclk);
	endtask : rtu_gap

	task automatic stop_test;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test

	// Cuts a hang short; the run needs about 80k cycles
	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 100000)
		begin
			num_errors++;
			stop_test;
		end
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial
	begin
		hresetn = 1'b0;
		hsel    = 1'b0;
		haddr   = 32'h0;
		htrans  = 2'h0;
		hwrite  = 1'b0;
		hsize   = 3'h2;
		hwdata  = 32'h0;
		bit_cyc = 16'd2083;
		par_m   = PAR_NONE;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (300) @(posedge hclk);
		// Defaults and refused values
		chk(OFS_STAT, 32'h0);
		chk(OFS_CTRL, 32'h0);
		chk(OFS_BAUD, 32'h0);
		chk(OFS_PAR, 32'h0);
		chk(OFS_IVAL, 32'h1);
		chk(OFS_SLAVE, 32'h1);
		chk(8'h20, 32'h0);
		wr(OFS_BAUD, 32'h6);
		chk(OFS_BAUD, 32'h0);
		wr(OFS_PAR, 32'h3);
		chk(OFS_PAR, 32'h0);
		wr(OFS_IVAL, 32'h00173B3B);
		chk(OFS_IVAL, 32'h00173B3B);
		wr(OFS_IVAL, 32'h00180000);
		chk(OFS_IVAL, 32'h00173B3B);
		wr(OFS_SLAVE, 32'hF8);
		chk(OFS_SLAVE, 32'h1);
		wr(OFS_SLAVE, 32'hF7);
		wr(OFS_BAUD, 32'h2);
		wr(OFS_CTRL, 32'h10);
		chk(OFS_SLAVE, 32'h1);
		chk(OFS_BAUD, 32'h0);
		chk(OFS_IVAL, 32'h1);
		// One character at the default rate
		wr(OFS_TXCHR, 32'h55);
		wait_idle;
		rx_is(8'h55);
		// Fast rate, every parity mode, character then separator
		wr(OFS_BAUD, 32'h5);
		bit_cyc <= 16'd174;
		for (int p = 0; p < 3; p++)
		begin
			par_m <= smr_par_e'(p);
			wr(OFS_PAR, p);
			wr(OFS_TXCHR, 32'h1A5);
			wait_idle;
			rx_is(8'hA5);
			rx_is(CHR_SEMI);
		end
		// Record pacing after enable
		par_m <= PAR_NONE;
		wr(OFS_PAR, 32'h0);
		wr(OFS_IVAL, 32'h2);
		wr(OFS_CTRL, 32'h1);
		@(posedge hclk); // Record-due sets one edge after the enable lands
		chk(OFS_STAT, 32'h4);
		wr(OFS_TXCHR, 32'h200);
		bus(1'b0, OFS_STAT, 32'h0, r);
		cmp({31'h0, r[2]}, 32'h0);
		for (int i = 0; i < 220 && r[2] !== 1'b1; i++)
			bus(1'b0, OFS_STAT, 32'h0, r);
		cmp({31'h0, r[2]}, 32'h1);
		wait_idle;
		rx_is(CHR_CR);
		rx_is(CHR_LF);
		// Modbus RTU: own frame kept, foreign frame dropped, byte order
		wr(OFS_SLAVE, 32'h5);
		wr(OFS_CTRL, 32'h6);
		rtu_gap;
		term.send(8'h05, 1'b0);
		term.send(8'h03, 1'b0);
		chk(OFS_STAT, 32'h28);
		chk(OFS_RXDAT, 32'h0503);
		rtu_gap;
		term.send(8'h07, 1'b0);
		term.send(8'h44, 1'b0);
		bus(1'b0, OFS_STAT, 32'h0, r);
		cmp({31'h0, r[3]}, 32'h0);
		wr(OFS_CTRL, 32'hE);
		rtu_gap;
		term.send(8'h05, 1'b0);
		term.send(8'h06, 1'b0);
		chk(OFS_RXDAT, 32'h0605);
		// Modbus ASCII: colon, two hex address digits, then data
		wr(OFS_CTRL, 32'h2);
		term.send(CHR_COLON, 1'b0);
		term.send(8'h30, 1'b0);
		term.send(8'h35, 1'b0);
		term.send(8'h30, 1'b0);
		term.send(8'h33, 1'b0);
		chk(OFS_STAT, 32'h28);
		chk(OFS_RXDAT, 32'h3033);
		// Receiver parity check, flag cleared by software
		wr(OFS_CTRL, 32'h0);
		par_m <= PAR_EVEN;
		wr(OFS_PAR, 32'h2);
		term.send(8'h11, 1'b1);
		bus(1'b0, OFS_STAT, 32'h0, r);
		cmp({31'h0, r[4]}, 32'h1);
		wr(OFS_STAT, 32'h8);
		bus(1'b0, OFS_STAT, 32'h0, r);
		cmp({31'h0, r[4]}, 32'h0);
		cmp({31'h0, term.bad}, 32'h0);
		stop_test;
	end
endmodule : test_smr_top
